// File: hdl/ics_pkg.sv
package ics_pkg;
	// ---------------------------------------------------------------
	// Addressing
	// ---------------------------------------------------------------
	localparam logic [6:0] ADDR_BASE = 7'h21;
	localparam int NUM_REGS = 16;
	localparam logic [3:0] REG_VOUT = 4'h0;
	localparam logic [7:0] VOUT_DEFAULT = 8'h32;
	localparam logic [7:0] VOUT_MAX = 8'h78;
	// ---------------------------------------------------------------
	// Settings store
	// ---------------------------------------------------------------
	localparam int NVM_PAGES = 3;
	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_HZ = 20_000_000;
	localparam int BUS_FREE_NS = 4700;
	localparam int BUS_FREE_CYC = (BUS_FREE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	// ---------------------------------------------------------------
	// Slave states
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		ICS_IDLE = 3'b000,
		ICS_RECV = 3'b001,
		ICS_ACK = 3'b010,
		ICS_SEND = 3'b011,
		ICS_MACK = 3'b100,
		ICS_IGNORE = 3'b101
	} ics_state_t;
endpackage : ics_pkg

// File: hdl/ics_slave.sv
// What this block does
// - Serve fast and high-speed bus rates
// - Data changes only while SCL low
// - Detect start and stop conditions
// - Bus busy until idle time after stop
// - Repeated start restarts address reception
// - Eight bits then acknowledge slot
// - Address byte: seven bits plus direction
// - Update: address, register, data bytes
// - Acknowledge address, register and data bytes
// - Write data on last data-bit fall
// - Address 21h to 28h by strap
// - Bus usable only while enabled
// - Output setting defaults, then follows writes up to 78h
// - Valid setting byte looks up commands
// - Load first page, then newest page
// - Enable low switches interface off
module ics_slave
	import ics_pkg::*;
#(
	parameter int BUS_FREE_CYCLES = BUS_FREE_CYC
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic enable,
	input wire logic input_undervoltage_lockout,
	input wire logic [2:0] strap_sel,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic [1:0] nvm_newest_page,
	input wire logic [NUM_REGS*8-1:0] nvm_page_data [NVM_PAGES],
	output logic [7:0] vref_cmd,
	output logic [7:0] fbdiv_cmd,
	output logic adjust_strobe,
	output logic bus_busy,
	output logic [7:0] vout_setting
);
	if (BUS_FREE_CYCLES < 1 || BUS_FREE_CYCLES > 65535) begin : g_bad_free
		$error("BUS_FREE_CYCLES must fit the 16-bit idle counter");
	end

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	logic [2:0] scl_q, scl_d, sda_q, sda_d, en_q, en_d, uv_q, uv_d;
	logic scl_s_q, scl_s_d, sda_s_q, sda_s_d, en_s_q, en_s_d, uv_s_q, uv_s_d;
	logic on_q, on_d;
	// Four clocks of latency: each SCL low phase must last at least that long
	always_comb begin
		scl_d = {scl_q[1:0], scl_in};
		sda_d = {sda_q[1:0], sda_in};
		en_d = {en_q[1:0], enable};
		uv_d = {uv_q[1:0], input_undervoltage_lockout};
		scl_s_d = (scl_q[1] == scl_q[2]) ? scl_q[2] : scl_s_q;
		sda_s_d = (sda_q[1] == sda_q[2]) ? sda_q[2] : sda_s_q;
		en_s_d = (en_q[1] == en_q[2]) ? en_q[2] : en_s_q;
		uv_s_d = (uv_q[1] == uv_q[2]) ? uv_q[2] : uv_s_q;
		on_d = en_s_d && !uv_s_d;
	end
	wire scl_rise = scl_s_d && !scl_s_q;
	wire scl_fall = !scl_s_d && scl_s_q;
	wire start_ev = scl_s_q && scl_s_d && sda_s_q && !sda_s_d;
	wire stop_ev = scl_s_q && scl_s_d && !sda_s_q && sda_s_d;

	// ---------------------------------------------------------------
	// Register file and settings load
	// ---------------------------------------------------------------
	logic [7:0] regs_q [NUM_REGS];
	logic [7:0] regs_d [NUM_REGS];
	logic [6:0] addr_q, addr_d;
	logic [1:0] load_q, load_d;
	logic [7:0] vout_q, vout_d, vref_q, vref_d, fbdiv_q, fbdiv_d;
	logic adj_q, adj_d;

	// Setting byte to reference and divider (fixed table)
	function automatic logic [15:0] vout_lookup(input logic [7:0] v);
		logic [7:0] div;
		div = (v > 8'h28) ? 8'h04 : (v > 8'h14) ? 8'h02 : 8'h01;
		vout_lookup = {8'((16'(v) * 16'h0008) / {8'h00, div}), div};
	endfunction : vout_lookup

	// ---------------------------------------------------------------
	// Byte engine
	// ---------------------------------------------------------------
	ics_state_t st_q, st_d;
	logic [7:0] sh_q, sh_d;
	logic [3:0] bit_q, bit_d;
	logic [1:0] byte_q, byte_d;
	logic rw_q, rw_d;
	logic [3:0] ptr_q, ptr_d;
	logic oe_q, oe_d;
	logic busy_q, busy_d;
	logic [15:0] free_q, free_d;
	logic [15:0] lk;

	always_comb begin
		st_d = st_q;
		sh_d = sh_q;
		bit_d = bit_q;
		byte_d = byte_q;
		rw_d = rw_q;
		ptr_d = ptr_q;
		oe_d = oe_q;
		regs_d = regs_q;
		addr_d = addr_q;
		load_d = load_q;
		vout_d = vout_q;
		vref_d = vref_q;
		fbdiv_d = fbdiv_q;
		adj_d = 1'b0;
		busy_d = busy_q;
		free_d = free_q;
		lk = 16'h0000;
		// Bus busy tracking
		if (start_ev) begin
			busy_d = 1'b1;
			free_d = 16'h0000;
		end else if (stop_ev) begin
			free_d = 16'(BUS_FREE_CYCLES);
		end else if (free_q != 16'h0000) begin
			free_d = free_q - 16'h0001;
			if (free_q == 16'h0001) busy_d = 1'b0;
		end
		if (!on_q) begin
			st_d = ICS_IDLE;
			oe_d = 1'b0;
			load_d = 2'd0;
		end else if (load_q == 2'd0) begin
			addr_d = ADDR_BASE + {4'h0, strap_sel};
			for (int i = 0; i < NUM_REGS; i++) regs_d[i] = nvm_page_data[0][i*8 +: 8];
			regs_d[REG_VOUT] = VOUT_DEFAULT;
			vout_d = VOUT_DEFAULT;
			load_d = 2'd1;
		end else if (load_q == 2'd1) begin
			if (nvm_newest_page != 2'd0 && nvm_newest_page < 2'(NVM_PAGES)) begin
				for (int i = 0; i < NUM_REGS; i++) regs_d[i] = nvm_page_data[nvm_newest_page][i*8 +: 8];
				regs_d[REG_VOUT] = VOUT_DEFAULT;
			end
			lk = vout_lookup(VOUT_DEFAULT);
			vref_d = lk[15:8];
			fbdiv_d = lk[7:0];
			adj_d = 1'b1;
			load_d = 2'd2;
		end else if (start_ev) begin
			st_d = ICS_RECV;
			bit_d = 4'd0;
			byte_d = 2'd0;
			oe_d = 1'b0;
		end else if (stop_ev) begin
			st_d = ICS_IDLE;
			oe_d = 1'b0;
		end else begin
			case (st_q)
				ICS_RECV: begin
					if (scl_rise) begin
						sh_d = {sh_q[6:0], sda_s_d};
						bit_d = bit_q + 4'd1;
					end else if (scl_fall && bit_q == 4'd8) begin
						st_d = ICS_ACK;
						oe_d = 1'b1;
						if (byte_q == 2'd0) begin
							if (sh_q[7:1] != addr_q) begin
								st_d = ICS_IGNORE;
								oe_d = 1'b0;
							end
							rw_d = sh_q[0];
						end else if (byte_q == 2'd1) begin
							ptr_d = sh_q[3:0];
						end else begin
							regs_d[ptr_q] = sh_q;
							if (ptr_q == REG_VOUT && sh_q <= VOUT_MAX) begin
								vout_d = sh_q;
								lk = vout_lookup(sh_q);
								vref_d = lk[15:8];
								fbdiv_d = lk[7:0];
								adj_d = 1'b1;
							end
						end
					end
				end
				ICS_ACK: begin
					if (scl_fall) begin
						bit_d = 4'd0;
						byte_d = (byte_q == 2'd2) ? 2'd2 : byte_q + 2'd1;
						if (byte_q == 2'd0 && rw_q) begin
							st_d = ICS_SEND;
							sh_d = regs_q[ptr_q];
							oe_d = !regs_q[ptr_q][7];
						end else begin
							st_d = ICS_RECV;
							oe_d = 1'b0;
						end
					end
				end
				ICS_SEND: begin
					if (scl_fall) begin
						bit_d = bit_q + 4'd1;
						if (bit_q == 4'd7) begin
							st_d = ICS_MACK;
							oe_d = 1'b0;
						end else begin
							sh_d = {sh_q[6:0], 1'b0};
							oe_d = !sh_q[6];
						end
					end
				end
				ICS_MACK: begin
					if (scl_rise) begin
						// Next byte goes out from the ack state at SCL fall
						st_d = sda_s_d ? ICS_IGNORE : ICS_ACK;
						ptr_d = ptr_q + 4'd1;
						byte_d = 2'd0;
					end
				end
				ICS_IDLE, ICS_IGNORE: begin
				end
				default: st_d = ICS_IDLE;
			endcase
		end
	end
	always_ff @(posedge clock) begin
		if (srst) begin
			scl_q <= 3'b111;
			sda_q <= 3'b111;
			scl_s_q <= 1'b1;
			sda_s_q <= 1'b1;
			en_q <= 3'b000;
			uv_q <= 3'b000;
			en_s_q <= 1'b0;
			uv_s_q <= 1'b0;
			on_q <= 1'b0;
			st_q <= ICS_IDLE;
			sh_q <= 8'h00;
			bit_q <= 4'd0;
			byte_q <= 2'd0;
			rw_q <= 1'b0;
			ptr_q <= 4'h0;
			oe_q <= 1'b0;
			for (int i = 0; i < NUM_REGS; i++) regs_q[i] <= 8'h00;
			addr_q <= ADDR_BASE;
			load_q <= 2'd0;
			vout_q <= VOUT_DEFAULT;
			vref_q <= 8'h00;
			fbdiv_q <= 8'h00;
			adj_q <= 1'b0;
			busy_q <= 1'b0;
			free_q <= 16'h0000;
		end else begin
			scl_q <= scl_d;
			sda_q <= sda_d;
			scl_s_q <= scl_s_d;
			sda_s_q <= sda_s_d;
			en_q <= en_d;
			uv_q <= uv_d;
			en_s_q <= en_s_d;
			uv_s_q <= uv_s_d;
			on_q <= on_d;
			st_q <= st_d;
			sh_q <= sh_d;
			bit_q <= bit_d;
			byte_q <= byte_d;
			rw_q <= rw_d;
			ptr_q <= ptr_d;
			oe_q <= oe_d;
			regs_q <= regs_d;
			addr_q <= addr_d;
			load_q <= load_d;
			vout_q <= vout_d;
			vref_q <= vref_d;
			fbdiv_q <= fbdiv_d;
			adj_q <= adj_d;
			busy_q <= busy_d;
			free_q <= free_d;
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe = oe_q;
	assign vref_cmd = vref_q;
	assign fbdiv_cmd = fbdiv_q;
	assign adjust_strobe = adj_q;
	assign bus_busy = busy_q;
	assign vout_setting = vout_q;
endmodule : ics_slave

// File: tb/ics_slave_monitor.sv
module ics_slave_monitor #(
	parameter int BUS_FREE_CYCLES = 4
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic enable,
	input wire logic input_undervoltage_lockout,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_oe,
	input wire logic adjust_strobe,
	input wire logic bus_busy,
	input wire logic [7:0] vout_setting
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int FREE_MAX = BUS_FREE_CYCLES + 8;
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	property p_rst; $fell(srst) |-> !sda_oe && !bus_busy && !adjust_strobe && vout_setting == 8'h32; endproperty
	a_rst: assert property (p_rst) else $error("bad state after reset");
	property p_off; (!enable || input_undervoltage_lockout) [*6] |-> !sda_oe; endproperty
	a_off: assert property (p_off) else $error("answer while off");
	property p_edge; $changed(sda_oe) |-> !scl_in; endproperty
	a_edge: assert property (p_edge) else $error("sda moved with scl high");
	property p_hold; sda_oe && $rose(scl_in) |-> sda_oe [*4]; endproperty
	a_hold: assert property (p_hold) else $error("low not held over high phase");
	property p_start; enable && !input_undervoltage_lockout && scl_in && $fell(sda_in) |-> ##[2:6] bus_busy; endproperty
	a_start: assert property (p_start) else $error("start not seen");
	property p_stop; bus_busy && scl_in && $rose(sda_in) |-> ##1 bus_busy [*4] ##[1:FREE_MAX] !bus_busy; endproperty
	a_stop: assert property (p_stop) else $error("bad bus free time");
	property p_load; $rose(enable) && !input_undervoltage_lockout |-> ##[2:10] adjust_strobe; endproperty
	a_load: assert property (p_load) else $error("no load at enable");
	property p_wr; bus_busy && $changed(vout_setting) |-> !scl_in; endproperty
	a_wr: assert property (p_wr) else $error("write not on scl low");
endmodule : ics_slave_monitor

bind ics_slave ics_slave_monitor #(.BUS_FREE_CYCLES(BUS_FREE_CYCLES)) u_mon (.clock(clock), .srst(srst),
	.enable(enable), .input_undervoltage_lockout(input_undervoltage_lockout), .scl_in(scl_in), .sda_in(sda_in),
	.sda_oe(sda_oe), .adjust_strobe(adjust_strobe), .bus_busy(bus_busy), .vout_setting(vout_setting));

// File: tb/ics_bus_master.sv
module ics_bus_master (
	input wire logic clock,
	input wire logic sda,
	output logic scl,
	output logic sda_m
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
	endtask : cyc
	// One 400 ns scl pulse: 5 clocks low, 3 high, data moved mid low
	task automatic bit_io(input logic b, output logic r);
		scl <= 1'b0;
		cyc(2);
		sda_m <= b;
		cyc(3);
		scl <= 1'b1;
		cyc(2);
		r = sda;
		cyc(1);
	endtask : bit_io
	task automatic start;
		scl <= 1'b0;
		cyc(2);
		sda_m <= 1'b1;
		cyc(6);
		scl <= 1'b1;
		cyc(4);
		sda_m <= 1'b0;
		cyc(4);
	endtask : start
	task automatic stop;
		scl <= 1'b0;
		cyc(2);
		sda_m <= 1'b0;
		cyc(6);
		scl <= 1'b1;
		cyc(4);
		sda_m <= 1'b1;
		cyc(20);
	endtask : stop
	// Eight bits then the acknowledge slot
	task automatic xfer(input logic [7:0] d, input logic am, output logic [7:0] q, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], q[i]);
		end
		bit_io(am, a);
		ack = !a;
	endtask : xfer
endmodule : ics_bus_master

// File: tb/tb_top.sv
module tb_top;
	import ics_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock, srst, enable, input_undervoltage_lockout, scl, sda_m, sda_out, sda_oe, adjust_strobe, bus_busy;
	logic [2:0] strap_sel;
	logic [1:0] nvm_newest_page;
	logic [NUM_REGS*8-1:0] nvm_page_data [NVM_PAGES];
	logic [7:0] vref_cmd, fbdiv_cmd, vout_setting, q;
	wire sda = sda_m & (sda_out | ~sda_oe);
	int fail_count = 0;
	int tests_run = 0;
	ics_slave #(.BUS_FREE_CYCLES(4)) DUT (.clock(clock), .srst(srst), .enable(enable),
		.input_undervoltage_lockout(input_undervoltage_lockout), .strap_sel(strap_sel), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .nvm_newest_page(nvm_newest_page), .nvm_page_data(nvm_page_data),
		.vref_cmd(vref_cmd), .fbdiv_cmd(fbdiv_cmd), .adjust_strobe(adjust_strobe), .bus_busy(bus_busy),
		.vout_setting(vout_setting));
	ics_bus_master u_m (.clock(clock), .sda(sda), .scl(scl), .sda_m(sda_m));
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic print_verdict;
		if (fail_count == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : print_verdict
	task automatic power(input logic [2:0] s);
		@(posedge clock);
		enable <= 1'b0;
		strap_sel <= s;
		repeat (8) @(posedge clock);
		enable <= 1'b1;
		repeat (20) @(posedge clock);
	endtask : power
	task automatic sel(input logic [6:0] adr, input logic rd, output logic ack);
		u_m.start();
		u_m.xfer({adr, rd}, 1'b1, q, ack);
	endtask : sel
	task automatic t_addr;
		logic k;
		for (int s = 0; s < 8; s++) begin
			power(3'(s));
			sel(ADDR_BASE + 7'(s), 1'b0, k);
			check(8'(k), 8'h01);
			u_m.stop();
			sel(ADDR_BASE + 7'(s) + 7'h01, 1'b0, k);
			check(8'(k), 8'h00);
			u_m.stop();
		end
	endtask : t_addr
	task automatic t_write;
		logic k;
		check(vout_setting, VOUT_DEFAULT);
		check(vref_cmd, 8'h64);
		check(fbdiv_cmd, 8'h04);
		sel(ADDR_BASE + 7'h07, 1'b0, k);
		u_m.xfer(8'h00, 1'b1, q, k);
		check(8'(k), 8'h01);
		u_m.xfer(8'h64, 1'b1, q, k);
		check(8'(k), 8'h01);
		check(vout_setting, 8'h64);
		check(vref_cmd, 8'hc8);
		check(fbdiv_cmd, 8'h04);
		u_m.xfer(8'h79, 1'b1, q, k);
		check(vout_setting, 8'h64);
		u_m.xfer(8'h10, 1'b1, q, k);
		check(vout_setting, 8'h10);
		check(vref_cmd, 8'h80);
		check(fbdiv_cmd, 8'h01);
		u_m.stop();
	endtask : t_write
	task automatic t_read;
		logic k;
		sel(ADDR_BASE + 7'h07, 1'b0, k);
		u_m.xfer(8'h01, 1'b1, q, k);
		sel(ADDR_BASE + 7'h07, 1'b1, k);
		check(8'(k), 8'h01);
		u_m.xfer(8'hff, 1'b1, q, k);
		check(q, 8'h5a);
		u_m.stop();
	endtask : t_read
	task automatic t_off;
		logic k;
		enable <= 1'b0;
		repeat (8) @(posedge clock);
		sel(ADDR_BASE + 7'h07, 1'b0, k);
		check(8'(k), 8'h00);
		u_m.stop();
		power(3'h7);
		input_undervoltage_lockout <= 1'b1;
		repeat (8) @(posedge clock);
		sel(ADDR_BASE + 7'h07, 1'b0, k);
		check(8'(k), 8'h00);
		u_m.stop();
	endtask : t_off
	initial begin
		srst = 1'b1;
		enable = 1'b0;
		input_undervoltage_lockout = 1'b0;
		strap_sel = 3'h0;
		nvm_newest_page = 2'h2;
		nvm_page_data[0] = {NUM_REGS{8'h11}};
		nvm_page_data[1] = {NUM_REGS{8'h33}};
		nvm_page_data[2] = {NUM_REGS{8'h5a}};
		repeat (2) @(posedge clock);
		srst <= 1'b0;
		t_addr();
		t_write();
		t_read();
		t_off();
		print_verdict();
	end
	initial begin
		#2_000_000;
		fail_count++;
		print_verdict();
	end
endmodule : tb_top
